// *** src/sram_cycle_map.vh ***
// Constants for the synchronous burst SRAM cycle control
// How it works
// - Chip select high with controller strobe low deselects; no address, data pins released.
// - Chip select low with processor strobe low starts a read burst at external address.
// - Controller strobe load starts a burst; write if store flag true, else read.
// - Both strobes high and step low advance to next burst address, read or write.
// - Both strobes high and step high suspend; current address reused, read or write.
// - Any write cycle leaves the data pins undriven and takes them as inputs.
// - Output enable acts at once; high forces drivers off, low only allows read drivers.
// - Every listed input combination of the cycle decode is supported.
// - Reads with output enable high still advance the burst counter normally.
// - Store flag true on all-lane store low, or gate low with a lane select low.
// - Two-bit counter steps four addresses, linear or interleaved, wraps on fifth clock.
// - Bypass low gives flow-through reads; high gives registered pipelined reads.
`ifndef SRAM_CYCLE_MAP_VH
`define SRAM_CYCLE_MAP_VH

// =====================================================================
// Widths
`define LANES      4
`define LANE_W     9
`define DATA_W     36
`define ADDR_W     8
`define BURST_W    2

// =====================================================================
// Reset values
`define RST_ADDR   8'h00
`define RST_BURST  2'h0
`define RST_DATA   36'h0

// =====================================================================
// Pin modes
`define ORDER_LINEAR   1'b0
`define MODE_FLOW      1'b0

`endif

// *** src/burst_counter.v ***
// Two-bit burst address counter with linear or interleaved order
`timescale 1ns/10ps
`include "sram_cycle_map.vh"

module burst_counter
(
    // Clock and reset
    input  wire                clk_i,
    input  wire                reset_i,
    // Cycle control
    input  wire                load_i,
    input  wire                step_i,
    input  wire                order_select_i,
    input  wire [`BURST_W-1:0] start_i,
    // Address bits used by this cycle
    output wire [`BURST_W-1:0] addr_lo_o
);

    reg  [`BURST_W-1:0] start_ff;
    reg  [`BURST_W-1:0] count_ff;
    reg  [`BURST_W-1:0] nxt_start;
    reg  [`BURST_W-1:0] nxt_count;

    // =================================================================
    // Order mapping
    function [`BURST_W-1:0] burst_addr;
        input [`BURST_W-1:0] start;
        input [`BURST_W-1:0] count;
        input                order;
        begin
            if (order == `ORDER_LINEAR)
                burst_addr = start + count;
            else
                burst_addr = start ^ count;
        end
    endfunction

    // =================================================================
    // Next state
    always @*
    begin
        nxt_start = start_ff;
        nxt_count = count_ff;
        if (load_i)
        begin
            nxt_start = start_i;
            nxt_count = `RST_BURST;
        end
        else if (step_i)
            nxt_count = count_ff + 2'h1;
    end

    assign addr_lo_o = burst_addr(nxt_start, nxt_count, order_select_i);

    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            start_ff <= `RST_BURST;
            count_ff <= `RST_BURST;
        end
        else
        begin
            start_ff <= nxt_start;
            count_ff <= nxt_count;
        end
    end

endmodule

// *** src/sync_burst_sram_cycle_control.v ***
// Cycle decode, burst addressing and data path of the synchronous burst SRAM
`timescale 1ns/10ps
`include "sram_cycle_map.vh"

module sync_burst_sram_cycle_control
(
    // Clock and reset
    input  wire                clk_i,
    input  wire                reset_i,
    // Synchronous cycle controls
    input  wire                chip_select_low_i,
    input  wire                proc_addr_strobe_i,
    input  wire                ctrl_addr_strobe_i,
    input  wire                burst_step_i,
    // Write controls
    input  wire                all_lane_store_i,
    input  wire                lane_store_gate_i,
    input  wire [`LANES-1:0]   lane_store_selects_i,
    // Mode pins
    input  wire                order_select_i,
    input  wire                bypass_output_reg_i,
    // Asynchronous output enable, active low
    input  wire                output_enable_n_i,
    // Address
    input  wire [`ADDR_W-1:0]  addr_i,
    // Data pins
    input  wire [`DATA_W-1:0]  data_i,
    output wire [`DATA_W-1:0]  data_o,
    output wire                data_oe_o,
    // Status
    output reg  [2:0]          cycle_kind_o,
    output reg  [`ADDR_W-1:0]  cur_addr_o
);

    // =================================================================
    // Cycle kinds
    localparam CYC_DESEL   = 3'h0;
    localparam CYC_BEGIN_R = 3'h1;
    localparam CYC_BEGIN_W = 3'h2;
    localparam CYC_CONT_R  = 3'h3;
    localparam CYC_CONT_W  = 3'h4;
    localparam CYC_SUSP_R  = 3'h5;
    localparam CYC_SUSP_W  = 3'h6;

    localparam DEPTH = 1 << `ADDR_W;

    // =================================================================
    // Declarations
    reg  [`DATA_W-1:0]  mem [0:DEPTH-1];
    reg  [2:0]          nxt_kind;
    reg                 store_flag;
    reg                 load;
    reg                 step;
    reg                 is_read;
    reg                 is_write;
    reg  [`ADDR_W-1:0]  nxt_addr;
    reg  [`ADDR_W-1:0]  addr_ff;
    reg  [`ADDR_W-1:0]  rd_addr_ff;
    reg                 read_act_ff;
    reg  [`DATA_W-1:0]  pipe_data_ff;
    reg                 drive_ff;
    reg                 flow_ff;
    reg                 nxt_drive;
    wire [`BURST_W-1:0] addr_lo;
    integer             i;

    // =================================================================
    // Store flag from the lane controls
    always @*
    begin
        store_flag = ~all_lane_store_i
                   | (~lane_store_gate_i & ~(&lane_store_selects_i));
    end

    // =================================================================
    // Cycle decode, every combination of the table covered
    always @*
    begin
        if (chip_select_low_i & ~ctrl_addr_strobe_i)
            nxt_kind = CYC_DESEL;
        else if (~chip_select_low_i & ~proc_addr_strobe_i)
            nxt_kind = CYC_BEGIN_R;
        else if (~chip_select_low_i & ~ctrl_addr_strobe_i)
            nxt_kind = store_flag ? CYC_BEGIN_W : CYC_BEGIN_R;
        else if (~burst_step_i)
            nxt_kind = store_flag ? CYC_CONT_W : CYC_CONT_R;
        else
            nxt_kind = store_flag ? CYC_SUSP_W : CYC_SUSP_R;
    end

    always @*
    begin
        load     = 1'b0;
        step     = 1'b0;
        is_read  = 1'b0;
        is_write = 1'b0;
        case (nxt_kind)
            CYC_DESEL:
            begin
                load = 1'b0;
            end
            CYC_BEGIN_R:
            begin
                load    = 1'b1;
                is_read = 1'b1;
            end
            CYC_BEGIN_W:
            begin
                load     = 1'b1;
                is_write = 1'b1;
            end
            CYC_CONT_R:
            begin
                step    = 1'b1;
                is_read = 1'b1;
            end
            CYC_CONT_W:
            begin
                step     = 1'b1;
                is_write = 1'b1;
            end
            CYC_SUSP_R:
            begin
                is_read = 1'b1;
            end
            CYC_SUSP_W:
            begin
                is_write = 1'b1;
            end
            default:
            begin
                load = 1'b0;
            end
        endcase
    end

    // =================================================================
    // Burst counter
    burst_counter u_burst_counter
    (
        .clk_i          (clk_i),
        .reset_i        (reset_i),
        .load_i         (load),
        .step_i         (step),
        .order_select_i (order_select_i),
        .start_i        (addr_i[`BURST_W-1:0]),
        .addr_lo_o      (addr_lo)
    );

    // Address of this cycle: external on load, else held upper bits
    always @*
    begin
        if (load)
            nxt_addr = {addr_i[`ADDR_W-1:`BURST_W], addr_lo};
        else
            nxt_addr = {addr_ff[`ADDR_W-1:`BURST_W], addr_lo};
    end

    // =================================================================
    // Output driver decision
    always @*
    begin
        if (bypass_output_reg_i == `MODE_FLOW)
            nxt_drive = is_read;
        else
            nxt_drive = is_read & read_act_ff;
    end

    // =================================================================
    // Control registers
    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            addr_ff      <= `RST_ADDR;
            rd_addr_ff   <= `RST_ADDR;
            read_act_ff  <= 1'b0;
            drive_ff     <= 1'b0;
            flow_ff      <= 1'b0;
            cycle_kind_o <= CYC_DESEL;
            cur_addr_o   <= `RST_ADDR;
        end
        else
        begin
            if (nxt_kind != CYC_DESEL)
                addr_ff <= nxt_addr;
            if (is_read)
                rd_addr_ff <= nxt_addr;
            read_act_ff  <= is_read;
            drive_ff     <= nxt_drive;
            flow_ff      <= (bypass_output_reg_i == `MODE_FLOW);
            cycle_kind_o <= nxt_kind;
            cur_addr_o   <= nxt_addr;
        end
    end

    // =================================================================
    // Pipelined output register
    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            pipe_data_ff <= `RST_DATA;
        else if (read_act_ff)
            pipe_data_ff <= mem[rd_addr_ff];
    end

    // =================================================================
    // Storage array with lane writes
    always @(posedge clk_i)
    begin
        if (is_write)
        begin
            for (i = 0; i < `LANES; i = i + 1)
            begin
                if (~all_lane_store_i | ~lane_store_selects_i[i])
                    mem[nxt_addr][i*`LANE_W +: `LANE_W] <=
                        data_i[i*`LANE_W +: `LANE_W];
            end
        end
    end

    // =================================================================
    // Data pins
    // Flow-through reads the array straight from the captured address
    assign data_o = flow_ff ? mem[rd_addr_ff] : pipe_data_ff;

    // Output enable gates without waiting for a clock edge
    assign data_oe_o = drive_ff & ~output_enable_n_i;

endmodule

// *** sim/sram_cycle_sva.sv ***
// Checker for the burst SRAM cycle decode and data drive
`timescale 1ns/10ps
`include "sram_cycle_map.vh"
module sram_cycle_sva
(
    input wire               clk_i,
    input wire               reset_i,
    input wire               chip_select_low_i,
    input wire               proc_addr_strobe_i,
    input wire               ctrl_addr_strobe_i,
    input wire               burst_step_i,
    input wire               all_lane_store_i,
    input wire               lane_store_gate_i,
    input wire [`LANES-1:0]  lane_store_selects_i,
    input wire               order_select_i,
    input wire               bypass_output_reg_i,
    input wire               output_enable_n_i,
    input wire [`ADDR_W-1:0] addr_i,
    input wire               data_oe_o,
    input wire [2:0]         cycle_kind_o,
    input wire [`ADDR_W-1:0] cur_addr_o
);
    wire st = ~all_lane_store_i | (~lane_store_gate_i & ~&lane_store_selects_i);
    wire rd = cycle_kind_o == 3'h1 || cycle_kind_o == 3'h3 || cycle_kind_o == 3'h5;
    wire go = ctrl_addr_strobe_i & (proc_addr_strobe_i | chip_select_low_i) & |cycle_kind_o;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    a_desel_quiet: assert property (chip_select_low_i & ~ctrl_addr_strobe_i
        |=> cycle_kind_o == 3'h0 && !data_oe_o) else $error("deselect missed");
    a_proc_read: assert property (~chip_select_low_i & ~proc_addr_strobe_i
        |=> cycle_kind_o == 3'h1 && cur_addr_o == $past(addr_i)) else $error("read begin");
    a_ctrl_load: assert property (~chip_select_low_i & proc_addr_strobe_i & ~ctrl_addr_strobe_i
        |=> cycle_kind_o == ($past(st) ? 3'h2 : 3'h1) && cur_addr_o == $past(addr_i))
        else $error("load begin");
    a_cont_next: assert property (go & ~burst_step_i & ~order_select_i
        |=> cur_addr_o == {$past(cur_addr_o[7:2]), $past(cur_addr_o[1:0]) + 2'h1}
        && cycle_kind_o == ($past(st) ? 3'h4 : 3'h3)) else $error("continue");
    a_susp_hold: assert property (go & burst_step_i
        |=> $stable(cur_addr_o) && cycle_kind_o == ($past(st) ? 3'h6 : 3'h5))
        else $error("suspend");
    a_write_quiet: assert property (cycle_kind_o inside {3'h2, 3'h4, 3'h6} |-> !data_oe_o)
        else $error("drive in write");
    a_oe_block: assert property (output_enable_n_i |-> !data_oe_o) else $error("oe high");
    a_flow_drive: assert property (!bypass_output_reg_i & rd & !output_enable_n_i
        |-> data_oe_o) else $error("flow read");
endmodule
bind sync_burst_sram_cycle_control sram_cycle_sva i_sva (.clk_i, .reset_i, .chip_select_low_i,
    .proc_addr_strobe_i, .ctrl_addr_strobe_i, .burst_step_i, .all_lane_store_i,
    .lane_store_gate_i, .lane_store_selects_i, .order_select_i, .bypass_output_reg_i,
    .output_enable_n_i, .addr_i, .data_oe_o, .cycle_kind_o, .cur_addr_o);

// *** sim/cache_ctrl_model.sv ***
// Processor-side bus model issuing one synchronous cycle per clock
`timescale 1ns/10ps
module cache_ctrl_model
(
    input  wire        clk_i,
    output reg         cs_o,
    output reg         ps_o,
    output reg         cs2_o,
    output reg         step_o,
    output reg         all_wr_o,
    output reg         gate_o,
    output reg  [3:0]  sel_o,
    output reg  [7:0]  a_o,
    output reg  [35:0] d_o
);
    initial
    begin
        // Idle on deselect so the data pins start undriven
        {cs_o, ps_o, cs2_o, step_o, all_wr_o, gate_o, sel_o} = 10'h37f;
        a_o = 8'h00;
        d_o = 36'h0;
    end
    // =====================================================
    // Kind 0 deselect, 1 proc load, 2 ctrl load, 3 step, 4 hold
    task cyc(input [2:0] k, input [3:0] ln, input [7:0] a, input [35:0] d);
    begin
        @(negedge clk_i);
        cs_o = k == 3'h0;
        ps_o = k != 3'h1;
        cs2_o = k > 3'h2;
        step_o = k == 3'h4;
        all_wr_o = ln != 4'hf;
        gate_o = ~|ln;
        sel_o = ~ln;
        a_o = a;
        d_o = |ln ? d : ~d_o;
    end
    endtask
endmodule

// *** sim/sync_burst_sram_cycle_control_tb_top.sv ***
// Self-checking bench for the burst SRAM cycle control
`timescale 1ns/10ps
module sync_burst_sram_cycle_control_tb_top;
    reg         clk_i, reset_i, order, bypass, oe_n;
    wire        cs, ps, cs2, step, all_wr, gate, oe;
    wire [3:0]  sel;
    wire [7:0]  a, cur;
    wire [2:0]  kind;
    wire [35:0] drv, q;
    integer     n_errors, check_count, i;
    cache_ctrl_model i_ctl (.clk_i(clk_i), .cs_o(cs), .ps_o(ps), .cs2_o(cs2), .step_o(step),
        .all_wr_o(all_wr), .gate_o(gate), .sel_o(sel), .a_o(a), .d_o(drv));
    sync_burst_sram_cycle_control i_dut (.clk_i(clk_i), .reset_i(reset_i),
        .chip_select_low_i(cs), .proc_addr_strobe_i(ps), .ctrl_addr_strobe_i(cs2),
        .burst_step_i(step), .all_lane_store_i(all_wr), .lane_store_gate_i(gate),
        .lane_store_selects_i(sel), .order_select_i(order), .bypass_output_reg_i(bypass),
        .output_enable_n_i(oe_n), .addr_i(a), .data_i(oe ? q : drv), .data_o(q),
        .data_oe_o(oe), .cycle_kind_o(kind), .cur_addr_o(cur));
    function [35:0] pat(input [2:0] n);
        pat = 36'h123456789 ^ {12{n}};
    endfunction
    task check(input [39:0] got, input [39:0] exp);
    begin
        check_count = check_count + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    task t(input [2:0] k, input [3:0] ln, input [7:0] ad, input [35:0] d);
    begin
        i_ctl.cyc(k, ln, ad, d);
        @(posedge clk_i);
        #1;
    end
    endtask
    task summarize;
    begin
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask
    // =====================================================
    // Scenarios
    task s_burst;
    begin
        t(3'h2, 4'hf, 8'h22, pat(0));
        check({kind, cur}, {3'h2, 8'h22});
        for (i = 1; i < 4; i = i + 1)
        begin
            t(3'h3, 4'hf, 8'h00, pat(i));
            check({oe, cur}, 8'h20 | ((2 + i) & 3));
        end
        t(3'h0, 4'h0, 8'h00, 36'h0);
        check({kind, oe}, 4'h0);
        t(3'h1, 4'hf, 8'h22, 36'h0);
        check({kind, oe, q}, {3'h1, 1'b1, pat(0)});
        for (i = 1; i < 5; i = i + 1)
        begin
            t(3'h3, 4'h0, 8'h00, 36'h0);
            check(q, pat(i & 3));
        end
    end
    endtask
    task s_order;
    begin
        @(negedge clk_i);
        order = 1'b1;
        t(3'h1, 4'h0, 8'h22, 36'h0);
        for (i = 1; i < 5; i = i + 1)
        begin
            t(3'h3, 4'h0, 8'h00, 36'h0);
            check(cur, 8'h20 | (2 ^ (i & 3)));
        end
        t(3'h4, 4'h0, 8'h00, 36'h0);
        check({kind, cur}, {3'h5, 8'h22});
        t(3'h0, 4'h0, 8'h00, 36'h0);
        t(3'h2, 4'h2, 8'h23, 36'hfffffffff);
        t(3'h1, 4'h0, 8'h23, 36'h0);
        check(q, pat(1) | 36'h00003fe00);
    end
    endtask
    task s_dummy;
    begin
        @(negedge clk_i);
        oe_n = 1'b1;
        t(3'h1, 4'h0, 8'h20, 36'h0);
        check(oe, 1'b0);
        t(3'h3, 4'h0, 8'h00, 36'h0);
        check(cur, 8'h21);
        t(3'h3, 4'hf, 8'h00, pat(7));
        check({kind, cur}, {3'h4, 8'h22});
        t(3'h4, 4'hf, 8'h00, pat(6));
        check({kind, oe, cur}, {3'h6, 1'b0, 8'h22});
        t(3'h0, 4'h0, 8'h00, 36'h0);
        @(negedge clk_i);
        oe_n = 1'b0;
        t(3'h1, 4'h0, 8'h22, 36'h0);
        check({oe, q}, {1'b1, pat(6)});
        @(negedge clk_i);
        oe_n = 1'b1;
        #1;
        check(oe, 1'b0);
        t(3'h0, 4'h0, 8'h00, 36'h0);
    end
    endtask
    task s_pipe;
    begin
        @(negedge clk_i);
        reset_i = 1'b1;
        bypass = 1'b1;
        oe_n = 1'b0;
        repeat (2) @(negedge clk_i);
        reset_i = 1'b0;
        t(3'h1, 4'h0, 8'h20, 36'h0);
        check(oe, 1'b0);
        t(3'h3, 4'h0, 8'h00, 36'h0);
        check({oe, q}, {1'b1, pat(2)});
        t(3'h0, 4'h0, 8'h00, 36'h0);
        check(oe, 1'b0);
    end
    endtask
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    initial
    begin
        #40000;
        n_errors = n_errors + 1;
        summarize;
    end
    initial
    begin
        n_errors = 0;
        check_count = 0;
        {reset_i, order, bypass, oe_n} = 4'h8;
        repeat (5) @(negedge clk_i);
        reset_i = 1'b0;
        s_burst;
        s_order;
        s_dummy;
        s_pipe;
        summarize;
    end
endmodule
